// [verilog/rws_params.svh]
// Register map, field positions and reset values of the row sequencer.
// Assumes it is included by bare name from the modules and the bench.
`ifndef RWS_PARAMS_SVH
`define RWS_PARAMS_SVH

// Register indexes on the plain register port
`define RWS_ADDR_TOTAL 7'h01
`define RWS_ADDR_ORIGIN_FIRST 7'h02
`define RWS_ADDR_ORIGIN_LAST 7'h21
`define RWS_ADDR_COUNT_FIRST 7'h22
`define RWS_ADDR_COUNT_LAST 7'h41
`define RWS_ADDR_PHASE 7'h42
`define RWS_ADDR_STRIDE 7'h43
`define RWS_ADDR_SCHEME 7'h44
`define RWS_ADDR_FLIP 7'h45
`define RWS_ADDR_BANKS 7'h51
`define RWS_ADDR_STATUS 7'h52
`define RWS_ADDR_PROGRESS 7'h53

// Field positions
`define RWS_SCHEME_MONO_BIT 0
`define RWS_SCHEME_XY_BIT 1
`define RWS_SCHEME_BIN_BIT 2
`define RWS_SCHEME_MONO_EXP_BIT 3
`define RWS_BANKS_TOP_OFF_BIT 5

// Reset values and limits
`define RWS_NUM_WIN 32
`define RWS_TOTAL_RST 16'h0c00
`define RWS_COUNT_FIRST_RST 16'h0c00
`define RWS_STRIDE_RST 16'h0001
`define RWS_SCHEME_RST 16'h0009
`define RWS_FLIP_MIRROR 2'h2
`define RWS_LAST_ROW 16'h0bff
`define RWS_SUB_LINES_MAX 16'h0600

`endif

// [verilog/rws_pkg.sv]
// Types shared by the row sequencer modules.
// Assumes the constant header sits on the include path.
package rws_pkg;

    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        RWS_IDLE = 4'h1,
        RWS_LOAD = 4'h2,
        RWS_RUN = 4'h4,
        RWS_DONE = 4'h8
    } rws_state_t;

    // Readout scheme in force for the frame
    typedef enum logic [1:0] {
        RWS_NORMAL = 2'h0,
        RWS_ROW_SUB = 2'h1,
        RWS_XY_SUB = 2'h2
    } rws_mode_t;

endpackage

// [verilog/rws_row_out.sv]
// Output stage: maps a logical row to its physical row and bank.
// Assumes one request per clock from the sequencer on the same clock.
`timescale 1ns/1ns
`include "rws_params.svh"

module rws_row_out (
    input wire logic i_clk, // Sequencer clock
    input wire logic i_rst_n, // Asynchronous reset, active low
    input wire logic i_valid, // Row request this cycle
    input wire logic [15:0] i_row, // Logical row number
    input wire logic i_flip, // Vertical reverse
    input wire logic [1:0] i_k, // Low bits of readout row index
    input wire rws_pkg::rws_mode_t i_mode, // Scheme in force
    input wire logic i_one_side, // Bottom bank only
    input wire logic i_last, // Last row of the frame
    output logic o_valid, // Row issued
    output logic [15:0] o_row, // Physical row
    output logic o_top, // Row goes to the top bank
    output logic o_burst_first, // First row of a burst
    output logic o_last // Last row of the frame
);

    logic nxt_top; // Bank for this row
    logic nxt_first; // Row opens a burst

    ////////////////////////////////////////////////////////////////////////
    // Bank split and burst grouping
    always_comb begin
        nxt_top = 1'b0;
        nxt_first = 1'b1;
        if (i_one_side) begin
            // Single-sided: every row on the bottom bank, one per burst
            nxt_top = 1'b0;
            nxt_first = 1'b1;
        end else begin
            unique case (i_mode)
                rws_pkg::RWS_ROW_SUB: begin
                    // Rows 1,4,5,8 bottom and 2,3,6,7 top
                    nxt_top = i_k[0] ^ i_k[1];
                    nxt_first = ~i_k[0];
                end
                rws_pkg::RWS_XY_SUB: begin
                    // Four rows share one burst
                    nxt_top = i_k[1];
                    nxt_first = (i_k == 2'h0);
                end
                default: begin
                    // Normal two-sided readout alternates banks
                    nxt_top = i_k[0];
                    nxt_first = ~i_k[0];
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_valid <= 1'b0;
            o_row <= 16'h0000;
            o_top <= 1'b0;
            o_burst_first <= 1'b0;
            o_last <= 1'b0;
        end else begin
            o_valid <= i_valid;
            o_last <= i_valid & i_last;
            if (i_valid) begin
                // Mirrored readout starts from the last array row
                o_row <= i_flip ? (`RWS_LAST_ROW - i_row) : i_row;
                o_top <= nxt_top;
                o_burst_first <= nxt_first;
            end
        end
    end

endmodule

// [verilog/rws_seq.sv]
// Row window and subsampling sequencer, with its register file.
// Assumes frame starts and register accesses come from the same clock.
//
// Strobed register access was decided locally.
`timescale 1ns/1ns
`include "rws_params.svh"

module rws_seq (
    input wire logic i_clk, // Sequencer clock, 125 MHz
    input wire logic i_rst_n, // Asynchronous reset, active low
    input wire logic [6:0] i_addr, // Register index
    input wire logic [15:0] i_wdata, // Write data
    input wire logic i_wr, // Write strobe
    input wire logic i_rd, // Read strobe
    input wire logic i_frame_start, // Start one readout cycle
    output logic [15:0] o_rdata, // Read data, cycle after strobe
    output logic o_busy, // Readout cycle in progress
    output logic o_frame_done, // Pulse when the cycle ends
    output logic o_row_valid, // Pulse per readout row
    output logic [15:0] o_row, // Physical row being read
    output logic o_row_top, // Row goes to the top bank
    output logic o_burst_first, // Row opens a burst
    output logic o_row_last // Last row of the cycle
);

    ////////////////////////////////////////////////////////////////////////
    // Register file
    logic [15:0] total_ff; // Total readout lines
    logic [15:0] origin_ff [`RWS_NUM_WIN]; // Window start rows
    logic [15:0] count_ff [`RWS_NUM_WIN]; // Window row counts
    logic [15:0] phase_ff; // Skip phase, held for software
    logic [15:0] stride_ff; // Skip stride
    logic [15:0] scheme_ff; // Colour and subsampling control
    logic [1:0] flip_ff; // Vertical flip field
    logic top_off_ff; // Upper bank off
    logic [15:0] rdata_ff; // Read data register
    logic [15:0] nxt_rdata; // Read data mux

    // Sequencer state
    rws_pkg::rws_state_t state_ff; // Sequencer state
    logic [5:0] win_ff; // Window index, 32 means past the end
    logic [15:0] offs_ff; // Row offset inside the window
    logic grp_ff; // Second row of a colour pair
    logic [15:0] lines_ff; // Readout rows issued so far
    logic busy_ff; // Busy output
    logic done_ff; // Done pulse

    // Frame decode
    logic sub_act; // Subsampling in force
    logic mono; // Monochrome array
    rws_pkg::rws_mode_t mode; // Scheme in force
    logic [15:0] eff_total; // Lines to issue
    logic [4:0] win_lo; // Window index inside range
    logic [15:0] cur_row; // Logical row issued now
    logic emit; // Row issued this cycle
    logic last_line; // Issued row is the final one
    logic [16:0] step; // Offset advance
    logic [16:0] nxt_offs; // Offset after advance
    logic win_end; // Window exhausted after this row

    ////////////////////////////////////////////////////////////////////////
    // Register writes; origins and counts reset to one full window
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            total_ff <= `RWS_TOTAL_RST;
            for (int i = 0; i < `RWS_NUM_WIN; i++) begin
                origin_ff[i] <= 16'h0000;
                count_ff[i] <= 16'h0000;
            end
            count_ff[0] <= `RWS_COUNT_FIRST_RST;
            phase_ff <= 16'h0000;
            stride_ff <= `RWS_STRIDE_RST;
            scheme_ff <= `RWS_SCHEME_RST;
            flip_ff <= 2'h0;
            top_off_ff <= 1'b0;
        end else if (i_wr) begin
            if (i_addr == `RWS_ADDR_TOTAL) begin
                total_ff <= i_wdata;
            end else if (i_addr >= `RWS_ADDR_ORIGIN_FIRST &&
                         i_addr <= `RWS_ADDR_ORIGIN_LAST) begin
                // Full 16-bit start row per window
                origin_ff[5'(i_addr - `RWS_ADDR_ORIGIN_FIRST)] <=
                    i_wdata;
            end else if (i_addr >= `RWS_ADDR_COUNT_FIRST &&
                         i_addr <= `RWS_ADDR_COUNT_LAST) begin
                // Counts start at index 34
                count_ff[5'(i_addr - `RWS_ADDR_COUNT_FIRST)] <=
                    i_wdata;
            end else if (i_addr == `RWS_ADDR_PHASE) begin
                phase_ff <= i_wdata;
            end else if (i_addr == `RWS_ADDR_STRIDE) begin
                stride_ff <= i_wdata;
            end else if (i_addr == `RWS_ADDR_SCHEME) begin
                scheme_ff <= i_wdata;
            end else if (i_addr == `RWS_ADDR_FLIP) begin
                flip_ff <= i_wdata[1:0];
            end else if (i_addr == `RWS_ADDR_BANKS) begin
                top_off_ff <= i_wdata[`RWS_BANKS_TOP_OFF_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped indexes read zero
    always_comb begin
        nxt_rdata = 16'h0000;
        if (i_addr == `RWS_ADDR_TOTAL) begin
            nxt_rdata = total_ff;
        end else if (i_addr >= `RWS_ADDR_ORIGIN_FIRST &&
                     i_addr <= `RWS_ADDR_ORIGIN_LAST) begin
            nxt_rdata = origin_ff[5'(i_addr - `RWS_ADDR_ORIGIN_FIRST)];
        end else if (i_addr >= `RWS_ADDR_COUNT_FIRST &&
                     i_addr <= `RWS_ADDR_COUNT_LAST) begin
            nxt_rdata = count_ff[5'(i_addr - `RWS_ADDR_COUNT_FIRST)];
        end else if (i_addr == `RWS_ADDR_PHASE) begin
            nxt_rdata = phase_ff;
        end else if (i_addr == `RWS_ADDR_STRIDE) begin
            nxt_rdata = stride_ff;
        end else if (i_addr == `RWS_ADDR_SCHEME) begin
            nxt_rdata = scheme_ff;
        end else if (i_addr == `RWS_ADDR_FLIP) begin
            nxt_rdata = {14'h0000, flip_ff};
        end else if (i_addr == `RWS_ADDR_BANKS) begin
            nxt_rdata = 16'(top_off_ff) << `RWS_BANKS_TOP_OFF_BIT;
        end else if (i_addr == `RWS_ADDR_STATUS) begin
            // Busy flag, window index and colour-pair phase
            nxt_rdata = {8'h00, busy_ff, grp_ff, win_ff};
        end else if (i_addr == `RWS_ADDR_PROGRESS) begin
            nxt_rdata = lines_ff;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_ff <= 16'h0000;
        end else begin
            rdata_ff <= i_rd ? nxt_rdata : 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame decode
    always_comb begin
        mono = scheme_ff[`RWS_SCHEME_MONO_BIT];
        // Subsampling is refused on single-sided readout
        sub_act = ~top_off_ff &
            (scheme_ff[`RWS_SCHEME_XY_BIT] | (stride_ff > 16'h0001));
        if (!sub_act) begin
            mode = rws_pkg::RWS_NORMAL;
        end else if (scheme_ff[`RWS_SCHEME_XY_BIT]) begin
            mode = rws_pkg::RWS_XY_SUB;
        end else begin
            mode = rws_pkg::RWS_ROW_SUB;
        end
        // Subsampled frames never issue more than half the array
        if (sub_act && total_ff > `RWS_SUB_LINES_MAX) begin
            eff_total = `RWS_SUB_LINES_MAX;
        end else begin
            eff_total = total_ff;
        end
        win_lo = win_ff[4:0];
        cur_row = 16'(origin_ff[win_lo] + offs_ff);
        emit = (state_ff == rws_pkg::RWS_RUN);
        last_line = (17'(lines_ff) + 17'h00001 >= 17'(eff_total));
    end

    // Offset advance: mono skips stride-1, colour skips pairs
    always_comb begin
        step = 17'h00001;
        if (sub_act) begin
            if (mono) begin
                step = 17'(stride_ff);
            end else if (!grp_ff) begin
                step = 17'h00001;
            end else begin
                step = 17'({stride_ff, 1'b0} - 17'h00001);
            end
        end
        nxt_offs = 17'(offs_ff) + step;
        win_end = (nxt_offs >= 17'(count_ff[win_lo]));
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: windows in ascending order until the total is reached or all 32 windows are passed
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_ff <= rws_pkg::RWS_IDLE;
            win_ff <= 6'h00;
            offs_ff <= 16'h0000;
            grp_ff <= 1'b0;
            lines_ff <= 16'h0000;
        end else begin
            unique case (state_ff)
                rws_pkg::RWS_IDLE: begin
                    // Starts while a frame runs are ignored
                    if (i_frame_start) begin
                        win_ff <= 6'h00;
                        offs_ff <= 16'h0000;
                        grp_ff <= 1'b0;
                        lines_ff <= 16'h0000;
                        state_ff <= rws_pkg::RWS_LOAD;
                    end
                end
                rws_pkg::RWS_LOAD: begin
                    if (win_ff == 6'(`RWS_NUM_WIN) || eff_total == 16'h0000)
                    begin
                        state_ff <= rws_pkg::RWS_DONE;
                    end else if (count_ff[win_lo] == 16'h0000) begin
                        // Empty window is passed over
                        win_ff <= 6'(win_ff + 6'h01);
                    end else begin
                        offs_ff <= 16'h0000;
                        grp_ff <= 1'b0;
                        state_ff <= rws_pkg::RWS_RUN;
                    end
                end
                rws_pkg::RWS_RUN: begin
                    lines_ff <= 16'(lines_ff + 16'h0001);
                    if (last_line) begin
                        state_ff <= rws_pkg::RWS_DONE;
                    end else if (win_end) begin
                        // Next window restarts the skip offset and the colour-pair phase
                        win_ff <= 6'(win_ff + 6'h01);
                        state_ff <= rws_pkg::RWS_LOAD;
                    end else begin
                        offs_ff <= nxt_offs[15:0];
                        grp_ff <= ~mono & sub_act & ~grp_ff;
                    end
                end
                rws_pkg::RWS_DONE: begin
                    state_ff <= rws_pkg::RWS_IDLE;
                end
                default: begin
                    state_ff <= rws_pkg::RWS_IDLE;
                end
            endcase
        end
    end

    // Busy level and done pulse
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            busy_ff <= (state_ff == rws_pkg::RWS_LOAD) ||
                (state_ff == rws_pkg::RWS_RUN) ||
                (state_ff == rws_pkg::RWS_IDLE && i_frame_start);
            done_ff <= (state_ff == rws_pkg::RWS_DONE);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Row output stage
    rws_row_out u_row_out (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_valid(emit),
        .i_row(cur_row),
        .i_flip(flip_ff == `RWS_FLIP_MIRROR),
        .i_k(lines_ff[1:0]),
        .i_mode(mode),
        .i_one_side(top_off_ff),
        .i_last(last_line),
        .o_valid(o_row_valid),
        .o_row(o_row),
        .o_top(o_row_top),
        .o_burst_first(o_burst_first),
        .o_last(o_row_last)
    );

    assign o_rdata = rdata_ff;
    assign o_busy = busy_ff;
    assign o_frame_done = done_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    reset_window_a: assert property (
        @(posedge i_clk) $rose(i_rst_n) |->
            count_ff[0] == `RWS_COUNT_FIRST_RST && origin_ff[0] == 16'h0000)
        else $error("reset window is not the full array");

    win_ascend_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        emit |=> win_ff >= $past(win_ff))
        else $error("window index went backwards");

    total_stop_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        emit && last_line |=> state_ff == rws_pkg::RWS_DONE
            ##1 state_ff == rws_pkg::RWS_IDLE)
        else $error("readout did not stop at the total");

    flip_row_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        emit |=> o_row_valid && o_row == (($past(flip_ff) == 2'h2) ?
            16'(16'h0bff - $past(cur_row)) : $past(cur_row)))
        else $error("row number does not follow flip setting");

    single_bank_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        o_row_valid && $past(top_off_ff) |-> !o_row_top)
        else $error("top bank used while switched off");

    mono_skip_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        emit && mode == rws_pkg::RWS_ROW_SUB && mono && !win_end &&
            !last_line |=> offs_ff == 16'($past(offs_ff) + $past(stride_ff)))
        else $error("monochrome skip distance wrong");

    pair_skip_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        emit && mode == rws_pkg::RWS_ROW_SUB && !mono && grp_ff &&
            !win_end && !last_line |=> !grp_ff &&
            offs_ff == 16'($past(offs_ff) + 2 * $past(stride_ff) - 1))
        else $error("colour pair skip distance wrong");

    sub_limit_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        busy_ff && sub_act |-> lines_ff <= 16'h0600)
        else $error("subsampled frame exceeds half height");

    row_bank_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        o_row_valid && $past(mode) == rws_pkg::RWS_ROW_SUB |->
            o_row_top == ($past(lines_ff[0]) ^ $past(lines_ff[1])))
        else $error("row subsampling bank split wrong");

    xy_burst_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        o_row_valid && $past(mode) == rws_pkg::RWS_XY_SUB |->
            o_burst_first == ($past(lines_ff[1:0]) == 2'h0))
        else $error("four-row burst grouping wrong");

endmodule

// [testbench/rws_capture.sv]
// Capture logic model that counts every readout row the sequencer issues and records the first 64.
// Assumes the sequencer clock and one row pulse at most per cycle.
`timescale 1ns/1ns

module rws_capture (
    input wire logic i_clk, // Sequencer clock
    input wire logic i_rst_n, // Asynchronous reset, active low
    input wire logic i_frame_start, // Clears the record for a new frame
    input wire logic i_row_valid, // Row pulse from the sequencer
    input wire logic [15:0] i_row, // Physical row
    input wire logic i_row_top, // Bank that carries the row
    input wire logic i_burst_first, // Row opens a burst
    input wire logic i_row_last // Final row of the frame
);
    logic [15:0] rows [0:63]; // Recorded rows in arrival order
    logic tops [0:63]; // Recorded banks
    logic fsts [0:63]; // Recorded burst openers
    int n_rows; // Rows seen this frame
    int last_idx; // Index of the row flagged last, -1 if none

    // Record rows; only the first 64 are kept, enough for every scenario
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            n_rows <= 0;
            last_idx <= -1;
        end else if (i_frame_start) begin
            n_rows <= 0;
            last_idx <= -1;
        end else if (i_row_valid) begin
            if (n_rows < 64) begin
                rows[n_rows] <= i_row;
                tops[n_rows] <= i_row_top;
                fsts[n_rows] <= i_burst_first;
            end
            if (i_row_last) begin
                last_idx <= n_rows;
            end
            n_rows <= n_rows + 1;
        end
    end
endmodule

// [testbench/rws_seq_tb_top.sv]
// Self-checking bench for the row sequencer and its register file.
// Assumes the capture model file is compiled first.
`timescale 1ns/1ns
`include "rws_params.svh"

module rws_seq_tb_top;
    logic i_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    logic i_frame_start = 1'b0;
    logic [6:0] i_addr = 7'h00;
    logic [15:0] i_wdata = 16'h0000, o_rdata, o_row;
    logic o_busy, o_frame_done, o_row_valid, o_row_top, o_burst_first;
    logic o_row_last;
    int mismatches = 0, n_checks = 0, seed = 32'h1ddebb20, i, m;
    logic [15:0] org, st;

    rws_seq dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .i_frame_start(i_frame_start), .o_rdata(o_rdata), .o_busy(o_busy),
        .o_frame_done(o_frame_done), .o_row_valid(o_row_valid),
        .o_row(o_row), .o_row_top(o_row_top),
        .o_burst_first(o_burst_first), .o_row_last(o_row_last));
    rws_capture cap (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_frame_start(i_frame_start), .i_row_valid(o_row_valid),
        .i_row(o_row), .i_row_top(o_row_top),
        .i_burst_first(o_burst_first), .i_row_last(o_row_last));

    ////////////////////////////////////////////////////////////////////////
    // Clock and watchdog; the whole run needs about two thousand cycles
    initial begin
        forever #4 i_clk = ~i_clk;
    end
    initial begin
        #(8 * 20000);
        mismatches++;
        final_report();
    end

    // Compare and count
    task automatic check(input string what, input logic [15:0] exp,
            input logic [15:0] got);
        n_checks++;
        if (exp !== got) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            mismatches++;
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [6:0] a, input logic [15:0] exp);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        check("rdata", exp, o_rdata);
    endtask
    // One readout cycle, bounded wait for its end
    task automatic frame(input int n);
        int t;
        @(posedge i_clk);
        i_frame_start <= 1'b1;
        @(posedge i_clk);
        i_frame_start <= 1'b0;
        @(negedge i_clk);
        check("busy", 16'h1, {15'h0, o_busy});
        for (t = 0; t < 2000 && o_frame_done !== 1'b1; t++) @(negedge i_clk);
        check("frame_done", 16'h1, {15'h0, o_frame_done});
        check("busy end", 16'h0, {15'h0, o_busy});
        @(negedge i_clk);
        check("row_count", n[15:0], cap.n_rows[15:0]);
        check("last", 16'(n - 1), cap.last_idx[15:0]);
    endtask
    // Expected physical row of readout row k for scenario mode md
    function automatic logic [15:0] exp_row(input logic [15:0] o,
            input int k, input int md);
        case (md)
            1, 7: return o + 16'(k * 2);
            2: return o + 16'(k * 6);
            3, 4: return o + 16'((k >> 1) * 4 + (k & 1));
            5: return 16'(`RWS_LAST_ROW) - o - 16'(k);
            default: return o + 16'(k);
        endcase
    endfunction
    function automatic logic exp_top(input int k, input int md);
        case (md)
            1, 2, 3: return 1'(k ^ (k >> 1));
            4, 7: return 1'(k >> 1);
            6: return 1'b0;
            default: return 1'(k);
        endcase
    endfunction
    // Burst opener: four rows per burst on row+col, one bottom-only
    function automatic logic exp_fst(input int k, input int md);
        case (md)
            4, 7: return (k % 4) == 0;
            6: return 1'b1;
            default: return (k % 2) == 0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (20) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rd(`RWS_ADDR_TOTAL, 16'h0c00);
        rd(`RWS_ADDR_ORIGIN_FIRST, 16'h0000);
        rd(`RWS_ADDR_COUNT_FIRST, 16'h0c00);
        rd(`RWS_ADDR_STRIDE, 16'h0001);
        rd(`RWS_ADDR_FLIP, 16'h0000);
        rd(7'h7f, 16'h0000);
        $display("test reset values done");
        // Modes: normal, mono skip 1, mono skip 5, colour skip 2,
        // colour row+col, flip, bottom bank only, mono row+col
        for (m = 0; m < 8; m++) begin
            org = 16'(($random(seed) & 32'h1ff) << 2);
            // No subsampling on the bottom-only pass
            st = (m == 2) ? 16'h0006 : (m == 0 || m == 5 || m == 6) ?
                16'h0001 : 16'h0002;
            wr(`RWS_ADDR_ORIGIN_FIRST, org);
            // Window spans stride times eight physical rows, enough for eight readout rows
            wr(`RWS_ADDR_COUNT_FIRST, 16'(st * 8));
            wr(`RWS_ADDR_TOTAL, 16'h0008);
            wr(`RWS_ADDR_SCHEME, (m == 3) ? 16'h0000 : (m == 4) ? 16'h0002 :
                (m == 7) ? 16'h000b : 16'h0009);
            wr(`RWS_ADDR_PHASE, (m == 2) ? 16'h0003 :
                (m == 1 || m == 7) ? 16'h0001 : 16'h0000);
            wr(`RWS_ADDR_STRIDE, st);
            wr(`RWS_ADDR_FLIP, (m == 5) ? 16'h0002 : 16'h0000);
            wr(`RWS_ADDR_BANKS, (m == 6) ? 16'h0020 : 16'h0000);
            frame(8);
            for (i = 0; i < 8; i++) begin
                check("row", exp_row(org, i, m), cap.rows[i]);
                check("top", 16'(exp_top(i, m)), 16'(cap.tops[i]));
                check("first", 16'(exp_fst(i, m)), 16'(cap.fsts[i]));
            end
            rd(`RWS_ADDR_PROGRESS, 16'h0008);
            $display("test mode %0d done", m);
        end
        // Two windows in descending place, read in index order
        wr(`RWS_ADDR_BANKS, 16'h0000);
        wr(`RWS_ADDR_SCHEME, 16'h0009);
        wr(`RWS_ADDR_STRIDE, 16'h0001);
        wr(`RWS_ADDR_ORIGIN_FIRST, 16'h0010);
        wr(`RWS_ADDR_COUNT_FIRST, 16'h0002);
        wr(`RWS_ADDR_ORIGIN_LAST, 16'h0004);
        wr(`RWS_ADDR_COUNT_LAST, 16'h0002);
        wr(`RWS_ADDR_TOTAL, 16'h0004);
        frame(4);
        check("win a", 16'h0011, cap.rows[1]);
        check("win b", 16'h0004, cap.rows[2]);
        check("win b end", 16'h0005, cap.rows[3]);
        $display("test two windows done");
        // Reset while idle, then subsampling with the reset total
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rd(`RWS_ADDR_SCHEME, 16'h0009);
        wr(`RWS_ADDR_STRIDE, 16'h0002);
        frame(1536);
        rd(`RWS_ADDR_PROGRESS, 16'h0600);
        $display("test default subsampled total done");
        final_report();
    end

    // Verdict
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
endmodule
